// ---- acs_pkg.sv ----
// Purpose: shared constants and types of the converter configuration and sequencing block
// Assumes: 8-bit register port, 13 shared pins, 10-bit successive approximation result
// Notes: offsets are word indices on the plain register port
`default_nettype none
package acs_pkg;
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int PIN_N = 13;
    localparam int CFG_W = 4;
    localparam int ACQ_W = 3;
    localparam int CLKSEL_W = 3;
    localparam int ACQCNT_W = 5;
    localparam int IDX_W = 4;
    localparam int DIV_W = 7;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_REFPIN = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_TIMFMT = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_RES_HI = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_RES_LO = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h6;

    // field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int REF_HIGH_BIT = 4;
    localparam int REF_LOW_BIT = 5;
    localparam int PINCFG_LSB = 0;
    localparam int FMT_JUSTIFY_BIT = 7;
    localparam int ACQ_LSB = 3;
    localparam int CLKSEL_LSB = 0;
    localparam int IRQ_DONE_BIT = 0;

    // writable bits and reset values
    localparam logic [DATA_W-1:0] REFPIN_WMASK = 8'h3f;
    localparam logic [DATA_W-1:0] TIMFMT_WMASK = 8'hbf;
    localparam logic [DATA_W-1:0] IRQ_WMASK = 8'h01;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [CFG_W-1:0] PINCFG_OPT_SET = 4'h0;
    localparam logic [CFG_W-1:0] PINCFG_OPT_CLEAR = 4'h7;
    localparam logic [1:0] INIT_LOAD_CNT = 2'h2;

    // conversion clock codes
    localparam logic [CLKSEL_W-1:0] CLK_DIV2 = 3'h0;
    localparam logic [CLKSEL_W-1:0] CLK_DIV8 = 3'h1;
    localparam logic [CLKSEL_W-1:0] CLK_DIV32 = 3'h2;
    localparam logic [CLKSEL_W-1:0] CLK_DIV4 = 3'h4;
    localparam logic [CLKSEL_W-1:0] CLK_DIV16 = 3'h5;
    localparam logic [CLKSEL_W-1:0] CLK_DIV64 = 3'h6;
    localparam logic [1:0] CLK_RC_LOW = 2'h3;

    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} acs_state_t;

    // pins below this limit are analog; codes 0..2 give 13 or more, so all analog
    function automatic logic [PIN_N-1:0] acsAnalogMask(input logic [CFG_W-1:0] cfg);
        logic [4:0] limit;
        logic [PIN_N-1:0] m;
        limit = 5'h0f - {1'b0, cfg};
        m = '0;
        for (int i = 0; i < PIN_N; i++) begin
            m[i] = (5'(i) < limit);
        end
        return m;
    endfunction
endpackage
`default_nettype wire

// ---- acs_tad_gen.sv ----
// Purpose: conversion clock enable generator, divided system clock or private rc oscillator
// Assumes: rc oscillator arrives as a raw pin level, far slower than clk_sys
// Notes: the divider restarts whenever run drops so every sequence on a divided system clock starts on a full period
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic [acs_pkg::CLKSEL_W-1:0] clkSel,
    // private rc oscillator pin
    input wire logic rcOscIn,
    // one-cycle conversion clock enable
    output logic tadTick
);
    import acs_pkg::*;

    logic rcSync1_q, rcSync2_q, rcPrev_q;
    logic [DIV_W-1:0] divCnt_q, divCnt_d;
    logic tick_q;
    logic [DIV_W-1:0] gap_q;

    // divide ratio of each system clock code
    function automatic logic [DIV_W-1:0] divOf(input logic [CLKSEL_W-1:0] sel);
        case (sel)
            CLK_DIV2: return 7'h02;
            CLK_DIV8: return 7'h08;
            CLK_DIV32: return 7'h20;
            CLK_DIV4: return 7'h04;
            CLK_DIV16: return 7'h10;
            CLK_DIV64: return 7'h40;
            default: return 7'h02;
        endcase
    endfunction

    // source decode and period end
    wire useRc = (clkSel[1:0] == CLK_RC_LOW);
    wire [DIV_W-1:0] divLimit = divOf(clkSel);
    wire divEnd = (divCnt_q == divLimit - 7'h01);
    wire rcEdge = rcSync2_q & ~rcPrev_q;
    assign divCnt_d = (!run || divEnd) ? '0 : divCnt_q + 7'h01;

    // rc pin synchroniser and edge history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rcSync1_q <= 1'b0;
            rcSync2_q <= 1'b0;
            rcPrev_q <= 1'b0;
        end else begin
            rcSync1_q <= rcOscIn;
            rcSync2_q <= rcSync1_q;
            rcPrev_q <= rcSync2_q;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            tick_q <= run & (useRc ? rcEdge : divEnd);
        end
    end

    assign tadTick = tick_q;

    // cycles in the current period, the enable cycle counted as one, only for checking
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= '0;
        end else if (!run) begin
            gap_q <= '0;
        end else if (tick_q) begin
            gap_q <= 7'h01;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
    end

    a_div_period: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tick_q && !useRc && $stable(clkSel) && $past(run)) |-> (gap_q == divLimit))
        else $error("conversion clock period differs from selected divide");

    a_rc_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (run && useRc && !rcEdge) |=> !tick_q)
        else $error("rc source selected but enable came without an rc edge");
endmodule // acs_tad_gen
`default_nettype wire

// ---- acs_pin_decode.sv ----
// Purpose: analog or digital role of each shared pin from the pin configuration field
// Assumes: port logic supplies output data and enables per pin on clk_sys
// Notes: analog pins never drive and read as zero on the digital path
`timescale 1ns/1ps
`default_nettype none
module acs_pin_decode (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // configuration
    input wire logic [acs_pkg::CFG_W-1:0] pinCfg,
    // port logic side
    input wire logic [acs_pkg::PIN_N-1:0] portOut,
    input wire logic [acs_pkg::PIN_N-1:0] portOe,
    output logic [acs_pkg::PIN_N-1:0] portIn,
    // pin side
    input wire logic [acs_pkg::PIN_N-1:0] pinIn,
    output logic [acs_pkg::PIN_N-1:0] pinOut,
    output logic [acs_pkg::PIN_N-1:0] pinOe,
    output logic [acs_pkg::PIN_N-1:0] pinAnalog
);
    import acs_pkg::*;

    logic [PIN_N-1:0] inSync1_q, inSync2_q, out_q, oe_q, analog_q;

    wire [PIN_N-1:0] analogNow = acsAnalogMask(pinCfg);

    // digital drive and read only on digital pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inSync1_q <= '0;
            inSync2_q <= '0;
            out_q <= '0;
            oe_q <= '0;
            analog_q <= '1;
        end else begin
            inSync1_q <= pinIn;
            inSync2_q <= inSync1_q;
            out_q <= portOut & ~analogNow;
            oe_q <= portOe & ~analogNow;
            analog_q <= analogNow;
        end
    end

    assign pinOut = out_q;
    assign pinOe = oe_q;
    assign pinAnalog = analog_q;
    assign portIn = inSync2_q & ~analog_q;

    a_analog_no_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 ((pinOe & pinAnalog) == '0) && ((portIn & pinAnalog) == '0))
        else $error("analog pin driven or read as digital");

    a_mask_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $stable(pinCfg) |=> (pinAnalog == acsAnalogMask($past(pinCfg))))
        else $error("pin analog mask does not match configuration code");
endmodule // acs_pin_decode
`default_nettype wire

// ---- acs_core.sv ----
// Purpose: register file, reference and pin routing, acquisition and conversion sequencing
// Assumes: comparator input is asynchronous and is high when the input is at or above dacCode
// Notes: one bit is resolved per conversion clock period; result registers keep old data
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module acs_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic [acs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [acs_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [acs_pkg::DATA_W-1:0] regRdata,
    // nonvolatile option
    input wire logic portAnalogDefault,
    // analog front end
    output logic lowRefExtSel,
    output logic highRefExtSel,
    output logic sampleEnable,
    output logic [acs_pkg::RES_W-1:0] dacCode,
    input wire logic compIn,
    // private rc oscillator
    input wire logic rcOscIn,
    // shared pins
    input wire logic [acs_pkg::PIN_N-1:0] portOut,
    input wire logic [acs_pkg::PIN_N-1:0] portOe,
    output logic [acs_pkg::PIN_N-1:0] portIn,
    input wire logic [acs_pkg::PIN_N-1:0] pinIn,
    output logic [acs_pkg::PIN_N-1:0] pinOut,
    output logic [acs_pkg::PIN_N-1:0] pinOe,
    output logic [acs_pkg::PIN_N-1:0] pinAnalog,
    // interrupt
    output logic irq
);
    import acs_pkg::*;

    acs_state_t state_q, state_d;
    logic on_q;
    logic [DATA_W-1:0] refPin_q, timFmt_q, resHi_q, resLo_q, irqStat_q, irqMask_q, rdata_q;
    logic [ACQCNT_W-1:0] acqCnt_q, acqCnt_d, acqSeen_q;
    logic [RES_W-1:0] sar_q, sar_d;
    logic [IDX_W-1:0] bitIdx_q, bitIdx_d;
    logic [1:0] initCnt_q;
    logic optSync1_q, optSync2_q, compSync1_q, compSync2_q;
    logic convDone;
    logic tadTick;

    function automatic logic [ACQCNT_W-1:0] acqPeriodsOf(input logic [ACQ_W-1:0] code);
        case (code)
            3'h0: return 5'h00;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h06;
            3'h4: return 5'h08;
            3'h5: return 5'h0c;
            3'h6: return 5'h10;
            default: return 5'h14;
        endcase
    endfunction

    // one-hot trial bit of the successive approximation
    function automatic logic [RES_W-1:0] trialBit(input logic [IDX_W-1:0] idx);
        logic [RES_W-1:0] m;
        m = '0;
        m[idx] = 1'b1;
        return m;
    endfunction

    // result placement into the high and low bytes
    function automatic logic [2*DATA_W-1:0] justify(input logic [RES_W-1:0] r,
                                                    input logic right);
        return right ? {6'h00, r} : {r, 6'h00};
    endfunction

    // register decode
    wire wrCtrl = regWrite && (regAddr == OFF_CTRL);
    wire wrRefPin = regWrite && (regAddr == OFF_REFPIN);
    wire wrTimFmt = regWrite && (regAddr == OFF_TIMFMT);
    wire wrIrqStat = regWrite && (regAddr == OFF_IRQ_STAT);
    wire wrIrqMask = regWrite && (regAddr == OFF_IRQ_MASK);
    wire busy = (state_q != ST_IDLE);
    wire wrOn = regWdata[CTRL_ON_BIT];
    wire wrGo = regWdata[CTRL_GO_BIT];
    // a new go is accepted at once; spacing after a conversion is software's duty
    wire goStart = wrCtrl && wrOn && wrGo && !busy;
    wire abort = wrCtrl && busy && !(wrOn && wrGo);

    // configuration fields
    wire [CFG_W-1:0] pinCfg = refPin_q[PINCFG_LSB +: CFG_W];
    wire [ACQ_W-1:0] acqCode = timFmt_q[ACQ_LSB +: ACQ_W];
    wire [CLKSEL_W-1:0] clkSel = timFmt_q[CLKSEL_LSB +: CLKSEL_W];
    wire rightJustify = timFmt_q[FMT_JUSTIFY_BIT];
    wire [ACQCNT_W-1:0] acqPeriods = acqPeriodsOf(acqCode);
    wire [RES_W-1:0] sarKeep = compSync2_q ? sar_q : (sar_q & ~trialBit(bitIdx_q));
    wire [2*DATA_W-1:0] resPair = justify(sar_d, rightJustify);

    // read selection; unmapped offsets read zero
    wire [DATA_W-1:0] ctrlView = {6'h00, busy, on_q};
    wire [DATA_W-1:0] readMux =
        (regAddr == OFF_CTRL) ? ctrlView :
        (regAddr == OFF_REFPIN) ? refPin_q :
        (regAddr == OFF_TIMFMT) ? timFmt_q :
        (regAddr == OFF_RES_HI) ? resHi_q :
        (regAddr == OFF_RES_LO) ? resLo_q :
        (regAddr == OFF_IRQ_STAT) ? irqStat_q :
        (regAddr == OFF_IRQ_MASK) ? irqMask_q : REG_RST;

    assign lowRefExtSel = refPin_q[REF_LOW_BIT];
    assign highRefExtSel = refPin_q[REF_HIGH_BIT];
    assign sampleEnable = on_q && (state_q != ST_CONV);
    assign dacCode = sar_q;
    assign regRdata = rdata_q;
    assign irq = |(irqStat_q & irqMask_q);

    always_comb begin
        state_d = state_q;
        acqCnt_d = acqCnt_q;
        sar_d = sar_q;
        bitIdx_d = bitIdx_q;
        convDone = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (goStart && acqPeriods == '0) begin
                    state_d = ST_CONV;
                    sar_d = trialBit(4'(RES_W - 1));
                    bitIdx_d = 4'(RES_W - 1);
                end else if (goStart) begin
                    state_d = ST_ACQ;
                    acqCnt_d = '0;
                end
            end
            ST_ACQ: begin
                if (tadTick && (acqCnt_q + 5'h01 == acqPeriods)) begin
                    state_d = ST_CONV;
                    sar_d = trialBit(4'(RES_W - 1));
                    bitIdx_d = 4'(RES_W - 1);
                end else if (tadTick) begin
                    acqCnt_d = acqCnt_q + 5'h01;
                end
            end
            ST_CONV: begin
                if (tadTick && bitIdx_q == '0) begin
                    sar_d = sarKeep;
                    convDone = 1'b1;
                    state_d = ST_IDLE;
                end else if (tadTick) begin
                    sar_d = sarKeep | trialBit(bitIdx_q - 4'h1);
                    bitIdx_d = bitIdx_q - 4'h1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (abort) begin
            state_d = ST_IDLE;
            convDone = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            acqCnt_q <= '0;
            sar_q <= '0;
            bitIdx_q <= '0;
        end else begin
            state_q <= state_d;
            acqCnt_q <= acqCnt_d;
            sar_q <= sar_d;
            bitIdx_q <= bitIdx_d;
        end
    end

    // option and comparator synchronisers, init counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            optSync1_q <= 1'b0;
            optSync2_q <= 1'b0;
            compSync1_q <= 1'b0;
            compSync2_q <= 1'b0;
            initCnt_q <= '0;
        end else begin
            optSync1_q <= portAnalogDefault;
            optSync2_q <= optSync1_q;
            compSync1_q <= compIn;
            compSync2_q <= compSync1_q;
            initCnt_q <= (initCnt_q == INIT_LOAD_CNT + 2'h1) ? initCnt_q : initCnt_q + 2'h1;
        end
    end

    // one-shot load at the third edge, once the option has passed both sync stages
    wire initLoad = (initCnt_q == INIT_LOAD_CNT);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            on_q <= 1'b0;
            refPin_q <= REG_RST;
            timFmt_q <= REG_RST;
            irqMask_q <= REG_RST;
        end else begin
            if (wrCtrl) on_q <= wrOn;
            // option picks the pin field default once after release
            if (initLoad) refPin_q[PINCFG_LSB +: CFG_W] <= optSync2_q ? PINCFG_OPT_SET
                                                                      : PINCFG_OPT_CLEAR;
            else if (wrRefPin) refPin_q <= regWdata & REFPIN_WMASK;
            if (wrTimFmt) timFmt_q <= regWdata & TIMFMT_WMASK;
            if (wrIrqMask) irqMask_q <= regWdata & IRQ_WMASK;
        end
    end

    // result load, done flag set wins over write-one clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resHi_q <= REG_RST;
            resLo_q <= REG_RST;
            irqStat_q <= REG_RST;
            rdata_q <= REG_RST;
        end else begin
            if (convDone) {resHi_q, resLo_q} <= resPair;
            irqStat_q[IRQ_DONE_BIT] <= convDone |
                (irqStat_q[IRQ_DONE_BIT] & ~(wrIrqStat & regWdata[IRQ_DONE_BIT]));
            rdata_q <= regRead ? readMux : REG_RST;
        end
    end

    // conversion clock enables while a sequence runs
    acs_tad_gen u_tad_gen (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(busy),
        .clkSel(clkSel),
        .rcOscIn(rcOscIn),
        .tadTick(tadTick)
    );

    acs_pin_decode u_pin_decode (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pinCfg(pinCfg),
        .portOut(portOut),
        .portOe(portOe),
        .portIn(portIn),
        .pinIn(pinIn),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .pinAnalog(pinAnalog)
    );

    // tad enables seen during acquisition, only for checking
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) acqSeen_q <= '0;
        else if (state_q != ST_ACQ) acqSeen_q <= '0;
        else if (tadTick) acqSeen_q <= acqSeen_q + 5'h01;
    end

    sequence s_go_taken;
        goStart && !abort;
    endsequence

    sequence s_conv_done;
        convDone;
    endsequence

    a_ref_low_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrRefPin && !initLoad |=> (lowRefExtSel == $past(regWdata[REF_LOW_BIT])))
        else $error("low reference route does not follow written bit");

    a_ref_high_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrRefPin && !initLoad |=> (highRefExtSel == $past(regWdata[REF_HIGH_BIT])))
        else $error("high reference route does not follow written bit");

    a_pin_default: assert property (@(posedge clk_sys) disable iff (!reset_n)
        initLoad |=> (pinCfg == ($past(optSync2_q) ? PINCFG_OPT_SET : PINCFG_OPT_CLEAR)))
        else $error("pin field default does not follow option");

    a_refpin_top_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (regRead && regAddr == OFF_REFPIN) |=> (regRdata[7:6] == 2'h0))
        else $error("reference register top bits read nonzero");

    a_timfmt_bit6_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (regRead && regAddr == OFF_TIMFMT) |=> (regRdata[6] == 1'b0))
        else $error("timing register bit 6 read nonzero");

    a_result_justify: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_conv_done |=> (rightJustify ? (resHi_q[7:2] == 6'h00) : (resLo_q[5:0] == 6'h00)))
        else $error("result placement does not follow format bit");

    a_acq_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_ACQ && state_d == ST_CONV) |-> (acqSeen_q + 5'h01 == acqPeriods))
        else $error("acquisition length differs from selected code");

    a_go_starts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_go_taken |=> ((acqPeriods == '0) ? (state_q == ST_CONV) : (state_q == ST_ACQ)))
        else $error("go did not start acquisition or conversion");

    a_done_effects: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_conv_done |=> (!busy && irqStat_q[IRQ_DONE_BIT] && ctrlView[CTRL_GO_BIT] == 1'b0))
        else $error("completion did not clear go and set done flag");

    a_reset_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> (state_q == ST_IDLE && !on_q && irqStat_q == REG_RST))
        else $error("converter not idle and off after reset");
endmodule // acs_core
`default_nettype wire

// ---- acs_bench.sv ----
// Purpose: self-checking bench of the converter configuration and sequencing block
// Assumes: comparator modelled from a 10-bit input level, rc pin toggles every 10 cycles
// Notes: divide-by-2 conversions are timed only, the comparator sync is too slow for them
`timescale 1ns/1ps
`default_nettype none
module acs_bench;
    import acs_pkg::*;
    logic clk_sys = 0;
    logic reset_n = 0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWrite = 0;
    logic regRead = 0;
    logic portAnalogDefault = 0;
    logic compIn = 0;
    logic rcOscIn = 0;
    logic [PIN_N-1:0] portOut = '0, portOe = '0, pinIn = '0;
    logic [DATA_W-1:0] regRdata, rv;
    logic lowRefExtSel, highRefExtSel, sampleEnable, irq;
    logic [RES_W-1:0] dacCode, vin = '0;
    logic [PIN_N-1:0] portIn, pinOut, pinOe, pinAnalog;
    int errors = 0, checks_done = 0, cyc = 0, n, lo, hi;
    logic [31:0] rs = 32'ha8e0; // seed 43232
    int acqT[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int divT[8] = '{2, 8, 32, 20, 4, 16, 64, 20};

    acs_core DUT (.clk_sys, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .portAnalogDefault, .lowRefExtSel, .highRefExtSel, .sampleEnable, .dacCode, .compIn,
        .rcOscIn, .portOut, .portOe, .portIn, .pinIn, .pinOut, .pinOe, .pinAnalog, .irq);

    // clock
    always #5 clk_sys = ~clk_sys;

    // comparator, rc oscillator and hang limit
    always @(posedge clk_sys) begin
        compIn <= (vin >= dacCode);
        if (cyc % 10 == 0) rcOscIn <= ~rcOscIn;
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // pins at or above 15 - code turn digital
    function automatic logic [PIN_N-1:0] amask(input int c);
        logic [PIN_N-1:0] r;
        for (int i = 0; i < PIN_N; i++) r[i] = (i + c < 15);
        return r;
    endfunction

    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rv = regRdata;
        chk(s, rv, e);
    endtask

    task automatic rst(input logic opt);
        reset_n <= 1'b0;
        portAnalogDefault <= opt;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask

    // one conversion, clock code and acquisition code both c, right justify on odd c
    task automatic conv(input int c, input logic mk);
        wr(4'h2, {c[0], 1'b0, c[2:0], c[2:0]});
        wr(4'h0, 8'h03);
        lo = (acqT[c] + 9) * divT[c];
        hi = (acqT[c] + 11) * divT[c] + 6;
        for (n = 0; n < hi && irq !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (mk) chk("conv time", 16'(n >= lo && n < hi), 16'h1);
        chk("irq", 16'(irq), 16'(mk));
        rdc(4'h5, 8'h01, "done flag");
        rdc(4'h0, 8'h01, "busy");
        if (c != 0) begin
            rdc(4'h3, c[0] ? 8'(vin >> 8) : vin[9:2], "res hi");
            rdc(4'h4, c[0] ? vin[7:0] : {vin[1:0], 6'h0}, "res lo");
        end
        wr(4'h5, 8'h01);
        @(posedge clk_sys);
        chk("irq clr", 16'(irq), 16'h0);
        repeat (2 * divT[c] + 2) @(posedge clk_sys);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        rst(1'b0);
        rdc(4'h1, 8'h07, "pin default");
        chk("analog pins", pinAnalog, amask(7));
        for (int c = 0; c < 16; c++) begin
            rs = xs(rs);
            portOut <= rs[12:0];
            portOe <= rs[25:13];
            pinIn <= rs[31:19];
            wr(4'h1, {rs[7:4], c[3:0]});
            repeat (4) @(posedge clk_sys);
            #1;
            chk("low ref", 16'(lowRefExtSel), 16'(rs[5]));
            chk("high ref", 16'(highRefExtSel), 16'(rs[4]));
            chk("analog pins", pinAnalog, amask(c));
            chk("pin out", pinOut, portOut & ~amask(c));
            chk("pin oe", pinOe, portOe & ~amask(c));
            chk("port in", portIn, pinIn & ~amask(c));
            rdc(4'h1, {2'h0, rs[5:4], c[3:0]}, "ref pin reg");
        end
        wr(4'h2, 8'hff);
        rdc(4'h2, 8'hbf, "timing reg");
        rdc(4'hf, 8'h00, "unmapped");
        wr(4'h6, 8'h01);
        for (int c = 0; c < 8; c++) begin
            rs = xs(rs);
            vin = (c == 1) ? 10'h0 : (c == 2) ? 10'h3ff : rs[9:0];
            conv(c, 1'b1);
        end
        wr(4'h6, 8'h00);
        conv(4, 1'b0);
        // abort a long sequence during acquisition by clearing go, then by reset
        wr(4'h2, 8'h3e);
        wr(4'h0, 8'h03);
        repeat (100) @(posedge clk_sys);
        wr(4'h0, 8'h01);
        rdc(4'h0, 8'h01, "abort");
        rdc(4'h5, 8'h00, "abort flag");
        wr(4'h0, 8'h03);
        repeat (100) @(posedge clk_sys);
        rdc(4'h0, 8'h03, "busy");
        chk("sampling", 16'(sampleEnable), 16'h1);
        rst(1'b1);
        rdc(4'h0, 8'h00, "ctrl");
        rdc(4'h5, 8'h00, "flag");
        rdc(4'h1, 8'h00, "pin default");
        chk("analog pins", pinAnalog, 16'h1fff);
        chk("irq", 16'(irq), 16'h0);
        report_and_stop;
    end
endmodule // acs_bench
`default_nettype wire
